// ---- rtl/lbr_pkg.sv ----
package lbr_pkg;

	// widths
	localparam int IP_W   = 32;
	localparam int DATA_W = 32;
	localparam int IDX_W  = 4;
	localparam int PIN_N  = 4;

	// model-specific register indices
	localparam logic [IDX_W-1:0] IDX_DEBUG_CONTROL       = 4'h0;
	localparam logic [IDX_W-1:0] IDX_BRANCH_SOURCE_IP    = 4'h1;
	localparam logic [IDX_W-1:0] IDX_BRANCH_TARGET_IP    = 4'h2;
	localparam logic [IDX_W-1:0] IDX_EXC_PRIOR_SOURCE_IP = 4'h3;
	localparam logic [IDX_W-1:0] IDX_EXC_PRIOR_TARGET_IP = 4'h4;

	// debug control field positions
	localparam int BIT_RECORDING_ENABLE   = 0;
	localparam int BIT_BRANCH_SINGLE_STEP = 1;
	localparam int BIT_PIN_SELECT_LO      = 2;
	localparam int BIT_TRACE_ENABLE       = 6;

	// reset values and masks
	localparam logic [DATA_W-1:0] CTRL_RESET    = 32'h00000000;
	localparam logic [DATA_W-1:0] CTRL_WR_MASK  = 32'h0000007f;
	localparam logic [IP_W-1:0]   IP_RESET      = 32'h00000000;
	localparam logic [DATA_W-1:0] RDATA_RESET   = 32'h00000000;
	localparam logic [1:0]        PRIV_KERNEL   = 2'h0;

	// pin pulse timing: cycles low, then cycles high before the next pulse
	localparam int PIN_LOW_CYCLES     = 1;
	localparam int PIN_RECOVER_CYCLES = 1;

	typedef struct packed {
		logic [24:0] reserved;
		logic        trace_enable;
		logic [3:0]  pin_select;
		logic        branch_single_step;
		logic        recording_enable;
	} lbr_ctrl_type;

	typedef struct packed {
		logic            valid;
		logic [IP_W-1:0] src;
		logic [IP_W-1:0] dst;
	} lbr_xfer_type;

	typedef enum logic [1:0] {
		LBR_PIN_IDLE    = 2'b00,
		LBR_PIN_LOW     = 2'b01,
		LBR_PIN_RECOVER = 2'b10
	} lbr_pin_state_type;

endpackage

// ---- rtl/lbr_pin_pulse.sv ----
`timescale 1ns/1ns
module lbr_pin_pulse (
	// clock and reset
	input  wire logic                   i_clock,
	input  wire logic                   i_rst_n,
	// per pin controls
	input  wire logic [lbr_pkg::PIN_N-1:0] i_pin_select,
	input  wire logic [lbr_pkg::PIN_N-1:0] i_bkpt_match,
	input  wire logic [lbr_pkg::PIN_N-1:0] i_perf_event,
	// pins, active low
	output logic      [lbr_pkg::PIN_N-1:0] o_bkpt_pin_n
);

	genvar g;
	generate
		for (g = 0; g < lbr_pkg::PIN_N; g++) begin : g_pin
			lbr_pkg::lbr_pin_state_type state_r;
			logic                        fire;

			// breakpoint match when selected, performance event otherwise
			assign fire = i_pin_select[g] ? i_bkpt_match[g] : i_perf_event[g];

			// low for one cycle, then high again: a pulse, not a level
			always_ff @(posedge i_clock or negedge i_rst_n) begin
				if (!i_rst_n) begin
					state_r <= lbr_pkg::LBR_PIN_IDLE;
				end else begin
					unique case (state_r)
						lbr_pkg::LBR_PIN_IDLE: begin
							if (fire) begin
								state_r <= lbr_pkg::LBR_PIN_LOW;
							end
						end
						lbr_pkg::LBR_PIN_LOW: begin
							state_r <= lbr_pkg::LBR_PIN_RECOVER;
						end
						lbr_pkg::LBR_PIN_RECOVER: begin
							state_r <= fire ? lbr_pkg::LBR_PIN_LOW : lbr_pkg::LBR_PIN_IDLE;
						end
						default: begin
							state_r <= lbr_pkg::LBR_PIN_IDLE;
						end
					endcase
				end
			end

			always_ff @(posedge i_clock or negedge i_rst_n) begin
				if (!i_rst_n) begin
					o_bkpt_pin_n[g] <= 1'b1;
				end else begin
					o_bkpt_pin_n[g] <= !(state_r == lbr_pkg::LBR_PIN_IDLE && fire)
						&& !(state_r == lbr_pkg::LBR_PIN_RECOVER && fire);
				end
			end
		end
	endgenerate

endmodule

// ---- rtl/lbr_capture.sv ----
`timescale 1ns/1ns
module lbr_capture (
	// clock and reset
	input  wire logic                          i_clock,
	input  wire logic                          i_rst_n,
	// qualifiers
	input  wire logic                          i_record,
	input  wire logic                          i_debug_exception,
	// events, addresses already segment offsets
	input  wire lbr_pkg::lbr_xfer_type         i_branch,
	input  wire lbr_pkg::lbr_xfer_type         i_intr,
	// recorded pairs
	output lbr_pkg::lbr_xfer_type              o_last_branch,
	output lbr_pkg::lbr_xfer_type              o_exc_prior
);

	logic take;

	// debug exceptions are never recorded and freeze all four registers
	assign take = i_record && !i_debug_exception;

	// last-branch pair
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_last_branch <= '{valid: 1'b0, src: lbr_pkg::IP_RESET, dst: lbr_pkg::IP_RESET};
		end else if (take && i_intr.valid) begin
			o_last_branch <= '{valid: 1'b1, src: i_intr.src, dst: i_intr.dst};
		end else if (take && i_branch.valid) begin
			o_last_branch <= '{valid: 1'b1, src: i_branch.src, dst: i_branch.dst};
		end
	end

	// prior pair: copy of last-branch before the interrupt overwrites it, or the branch taken in the same cycle
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_exc_prior <= '{valid: 1'b0, src: lbr_pkg::IP_RESET, dst: lbr_pkg::IP_RESET};
		end else if (take && i_intr.valid) begin
			if (i_branch.valid) begin
				o_exc_prior <= '{valid: 1'b1, src: i_branch.src, dst: i_branch.dst};
			end else begin
				o_exc_prior <= o_last_branch;
			end
		end
	end

endmodule

// ---- rtl/lbr_top.sv ----
`timescale 1ns/1ns
// Notes on behaviour
// - recording enable, control bit 0, captures last branch and last interrupt pairs
// - any debug exception clears recording enable before its handler starts
// - branch single-step bit 1 makes single-step flag trap on taken branches and interrupts only
// - pin-select bits 2 to 5 route breakpoint matches to the four pins
// - a reported match drives its active-low pin low, then high again
// - with pin-select clear the pin reports performance events, execution unaffected
// - trace enable bit 6 emits branch trace messages, stalling is accepted
// - while tracing, the four recorded address registers hold no meaningful value
// - control writes accepted only at privilege level 0 or real-address mode
// - the four recorded address registers are 32 bits wide
// - taken branch loads its own address as source, destination as target
// - interrupt or non-debug exception loads interrupted address and handler address
// - interrupt copies last-branch pair into prior pair before overwriting it
// - all recorded addresses are offsets within the current code segment
// - debug exceptions themselves are never recorded
// - a debug exception leaves all four recorded registers unchanged
// - the four recorded registers are readable with the register read instruction
module lbr_top (
	// clock and reset
	input  wire logic                          i_clock,
	input  wire logic                          i_rst_n,
	// model-specific register access
	input  wire logic                          i_model_reg_read,
	input  wire logic                          i_model_reg_write,
	input  wire logic [lbr_pkg::IDX_W-1:0]     i_reg_index,
	input  wire logic [lbr_pkg::DATA_W-1:0]    i_reg_wdata,
	input  wire logic [1:0]                    i_priv_level,
	input  wire logic                          i_real_mode,
	output logic      [lbr_pkg::DATA_W-1:0]    o_reg_rdata,
	output logic                               o_reg_done,
	output logic                               o_reg_fault,
	// control transfers from the core, linear addresses
	input  wire logic [lbr_pkg::IP_W-1:0]      i_code_seg_base,
	input  wire logic                          i_branch_taken,
	input  wire logic [lbr_pkg::IP_W-1:0]      i_branch_from,
	input  wire logic [lbr_pkg::IP_W-1:0]      i_branch_to,
	input  wire logic                          i_intr_taken,
	input  wire logic [lbr_pkg::IP_W-1:0]      i_intr_from,
	input  wire logic [lbr_pkg::IP_W-1:0]      i_intr_to,
	input  wire logic                          i_debug_exception,
	// single-step
	input  wire logic                          i_single_step_flag,
	input  wire logic                          i_instr_retired,
	output logic                               o_step_trap,
	// breakpoint and performance pins
	input  wire logic [lbr_pkg::PIN_N-1:0]     i_bkpt_match,
	input  wire logic [lbr_pkg::PIN_N-1:0]     i_perf_event,
	output logic      [lbr_pkg::PIN_N-1:0]     o_bkpt_pin_n,
	// branch trace messages
	input  wire logic                          i_trace_ready,
	output logic                               o_trace_valid,
	output logic      [lbr_pkg::IP_W-1:0]      o_trace_from,
	output logic      [lbr_pkg::IP_W-1:0]      o_trace_to,
	output logic                               o_core_stall,
	// debug exception handshake
	output logic                               o_debug_entry_ok
);

	logic                  rst_meta_r;
	logic                  rst_sync_r;
	lbr_pkg::lbr_ctrl_type ctrl_r;
	lbr_pkg::lbr_ctrl_type ctrl_nxt;
	lbr_pkg::lbr_xfer_type branch_off;
	lbr_pkg::lbr_xfer_type intr_off;
	lbr_pkg::lbr_xfer_type last_branch;
	lbr_pkg::lbr_xfer_type exc_prior;
	lbr_pkg::lbr_xfer_type trace_r;
	logic                  write_allowed;
	logic                  ctrl_wr;
	logic                  record;
	logic                  trace_load;
	logic [lbr_pkg::DATA_W-1:0] rdata_nxt;
	logic                       index_ok;

	// reset release through two flip-flops
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end

	// addresses held as offsets into the current code segment
	assign branch_off = '{
		valid: i_branch_taken,
		src:   i_branch_from - i_code_seg_base,
		dst:   i_branch_to - i_code_seg_base
	};
	assign intr_off = '{
		valid: i_intr_taken,
		src:   i_intr_from - i_code_seg_base,
		dst:   i_intr_to - i_code_seg_base
	};

	// control register writes
	assign write_allowed = (i_priv_level == lbr_pkg::PRIV_KERNEL) || i_real_mode;
	assign ctrl_wr       = i_model_reg_write && write_allowed
		&& (i_reg_index == lbr_pkg::IDX_DEBUG_CONTROL);

	always_comb begin
		ctrl_nxt = ctrl_r;
		if (ctrl_wr) begin
			ctrl_nxt = lbr_pkg::lbr_ctrl_type'(i_reg_wdata & lbr_pkg::CTRL_WR_MASK);
		end
		if (i_debug_exception) begin
			ctrl_nxt.recording_enable = 1'b0;
		end
		ctrl_nxt.reserved = '0;
	end

	always_ff @(posedge i_clock or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			ctrl_r <= lbr_pkg::lbr_ctrl_type'(lbr_pkg::CTRL_RESET);
		end else begin
			ctrl_r <= ctrl_nxt;
		end
	end

	// handler may start once recording enable is seen clear
	always_ff @(posedge i_clock or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			o_debug_entry_ok <= 1'b0;
		end else begin
			o_debug_entry_ok <= i_debug_exception;
		end
	end

	// recording frozen while trace messages run
	assign record = ctrl_r.recording_enable && !ctrl_r.trace_enable;

	lbr_capture u_capture (
		.i_clock           (i_clock),
		.i_rst_n           (rst_sync_r),
		.i_record          (record),
		.i_debug_exception (i_debug_exception),
		.i_branch          (branch_off),
		.i_intr            (intr_off),
		.o_last_branch     (last_branch),
		.o_exc_prior       (exc_prior)
	);

	// single-step on instructions or on branches
	always_ff @(posedge i_clock or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			o_step_trap <= 1'b0;
		end else if (ctrl_r.branch_single_step) begin
			o_step_trap <= i_single_step_flag && (i_branch_taken || i_intr_taken);
		end else begin
			o_step_trap <= i_single_step_flag && i_instr_retired;
		end
	end

	lbr_pin_pulse u_pins (
		.i_clock      (i_clock),
		.i_rst_n      (rst_sync_r),
		.i_pin_select (ctrl_r.pin_select),
		.i_bkpt_match (i_bkpt_match),
		.i_perf_event (i_perf_event),
		.o_bkpt_pin_n (o_bkpt_pin_n)
	);

	// branch trace message holding register
	assign trace_load = ctrl_r.trace_enable && !i_debug_exception
		&& (i_branch_taken || i_intr_taken)
		&& (!trace_r.valid || i_trace_ready);

	always_ff @(posedge i_clock or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			trace_r <= '{valid: 1'b0, src: lbr_pkg::IP_RESET, dst: lbr_pkg::IP_RESET};
		end else if (trace_load) begin
			trace_r <= i_intr_taken ? intr_off : branch_off;
			trace_r.valid <= 1'b1;
		end else if (i_trace_ready) begin
			trace_r.valid <= 1'b0;
		end
	end

	assign o_trace_valid = trace_r.valid;
	assign o_trace_from  = trace_r.src;
	assign o_trace_to    = trace_r.dst;
	// stall the core while a message waits, the throughput loss is accepted
	assign o_core_stall  = trace_r.valid && !i_trace_ready;

	// register read mux
	always_comb begin
		rdata_nxt = lbr_pkg::RDATA_RESET;
		index_ok  = 1'b1;
		unique case (i_reg_index)
			lbr_pkg::IDX_DEBUG_CONTROL: begin
				rdata_nxt = ctrl_r & lbr_pkg::CTRL_WR_MASK;
			end
			lbr_pkg::IDX_BRANCH_SOURCE_IP: begin
				rdata_nxt = last_branch.src;
			end
			lbr_pkg::IDX_BRANCH_TARGET_IP: begin
				rdata_nxt = last_branch.dst;
			end
			lbr_pkg::IDX_EXC_PRIOR_SOURCE_IP: begin
				rdata_nxt = exc_prior.src;
			end
			lbr_pkg::IDX_EXC_PRIOR_TARGET_IP: begin
				rdata_nxt = exc_prior.dst;
			end
			default: begin
				index_ok = 1'b0;
			end
		endcase
	end

	// read data
	always_ff @(posedge i_clock or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			o_reg_rdata <= lbr_pkg::RDATA_RESET;
		end else if (i_model_reg_read && index_ok) begin
			o_reg_rdata <= rdata_nxt;
		end
	end

	// completion and fault, one cycle after the request
	always_ff @(posedge i_clock or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			o_reg_done  <= 1'b0;
			o_reg_fault <= 1'b0;
		end else begin
			o_reg_done  <= i_model_reg_read || i_model_reg_write;
			o_reg_fault <= (i_model_reg_read && !index_ok)
				|| (i_model_reg_write && !ctrl_wr);
		end
	end

endmodule

// ---- tb/lbr_top_chk.sv ----
`timescale 1ns/1ns
module lbr_top_chk (
	// clock and reset
	input wire logic                      i_clock,
	input wire logic                      i_rst_n,
	// register access
	input wire logic                      i_model_reg_read,
	input wire logic                      i_model_reg_write,
	input wire logic [1:0]                i_priv_level,
	input wire logic                      i_real_mode,
	input wire logic                      o_reg_done,
	input wire logic                      o_reg_fault,
	// core events
	input wire logic                      i_debug_exception,
	input wire logic                      o_debug_entry_ok,
	input wire logic                      i_single_step_flag,
	input wire logic                      o_step_trap,
	// pins
	input wire logic [lbr_pkg::PIN_N-1:0] i_bkpt_match,
	input wire logic [lbr_pkg::PIN_N-1:0] i_perf_event,
	input wire logic [lbr_pkg::PIN_N-1:0] o_bkpt_pin_n,
	// trace
	input wire logic                      i_trace_ready,
	input wire logic                      o_trace_valid,
	input wire logic [lbr_pkg::IP_W-1:0]  o_trace_from,
	input wire logic                      o_core_stall
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);

	sequence s_req;
		i_model_reg_read || i_model_reg_write;
	endsequence
	sequence s_low_then_high;
		!o_bkpt_pin_n[0] ##1 o_bkpt_pin_n[0];
	endsequence

	a_done_after_req: assert property (s_req |=> o_reg_done) else $error("no done after request");
	a_done_has_cause: assert property (o_reg_done |-> $past(i_model_reg_read || i_model_reg_write))
		else $error("done without request");
	a_user_write_refused: assert property (
		i_model_reg_write && i_priv_level != lbr_pkg::PRIV_KERNEL && !i_real_mode |=> o_reg_fault && o_reg_done)
		else $error("user write not refused");
	a_debug_entry_next: assert property (i_debug_exception |=> o_debug_entry_ok)
		else $error("no debug entry");
	a_entry_has_cause: assert property (o_debug_entry_ok |-> $past(i_debug_exception))
		else $error("entry without debug exception");
	a_step_needs_flag: assert property (o_step_trap |-> $past(i_single_step_flag))
		else $error("trap without step flag");
	a_pin_pulse_shape: assert property ($fell(o_bkpt_pin_n[0]) |-> s_low_then_high)
		else $error("pin not a pulse");
	a_pin_has_cause: assert property ($fell(o_bkpt_pin_n[0]) |-> $past(i_bkpt_match[0] || i_perf_event[0]))
		else $error("pin low without event");
	a_stall_rule: assert property (o_core_stall == (o_trace_valid && !i_trace_ready))
		else $error("stall mismatch");
	a_trace_held: assert property (o_trace_valid && !i_trace_ready |=> o_trace_valid && $stable(o_trace_from))
		else $error("trace message dropped");
endmodule

bind lbr_top lbr_top_chk i_chk (.i_clock, .i_rst_n, .i_model_reg_read, .i_model_reg_write, .i_priv_level,
	.i_real_mode, .o_reg_done, .o_reg_fault, .i_debug_exception, .o_debug_entry_ok, .i_single_step_flag,
	.o_step_trap, .i_bkpt_match, .i_perf_event, .o_bkpt_pin_n, .i_trace_ready, .o_trace_valid, .o_trace_from,
	.o_core_stall);

// ---- tb/lbr_top_tb_top.sv ----
`timescale 1ns/1ns
module lbr_top_tb_top;
	typedef struct packed {
		logic        wr;
		logic [3:0]  idx;
		logic [31:0] wd;
		logic [1:0]  priv;
		logic        rm;
		logic        flt;
		logic [31:0] rd;
	} lbr_row_type;
	logic              i_clock;
	logic              i_rst_n;
	logic              rd_q, wr_q, rm, br, it, db, rt, ssf, rdy;
	logic [3:0]        idx, bm, pe;
	logic [31:0]       wd, base, f, t;
	logic [1:0]        priv;
	wire logic [31:0]  rdata, tfrom, tto;
	wire logic [3:0]   pins;
	wire logic         done, fault, trap, tvalid, stall, entry;
	int                n_errors = 0;
	int                samples_checked = 0;
	lbr_row_type       rows [10];

	lbr_top i_dut (.i_clock, .i_rst_n, .i_model_reg_read(rd_q), .i_model_reg_write(wr_q), .i_reg_index(idx),
		.i_reg_wdata(wd), .i_priv_level(priv), .i_real_mode(rm), .o_reg_rdata(rdata), .o_reg_done(done),
		.o_reg_fault(fault), .i_code_seg_base(base), .i_branch_taken(br), .i_branch_from(f), .i_branch_to(t),
		.i_intr_taken(it), .i_intr_from(f), .i_intr_to(t), .i_debug_exception(db), .i_single_step_flag(ssf),
		.i_instr_retired(rt), .o_step_trap(trap), .i_bkpt_match(bm), .i_perf_event(pe), .o_bkpt_pin_n(pins),
		.i_trace_ready(rdy), .o_trace_valid(tvalid), .o_trace_from(tfrom), .o_trace_to(tto),
		.o_core_stall(stall), .o_debug_entry_ok(entry));

	initial begin
		i_clock = 1'b0;
		forever #4 i_clock = ~i_clock;
	end

	task automatic summarize();
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input logic ok, input string msg);
		samples_checked++;
		if (!ok) begin
			n_errors++;
			$display("unexpected %0t %s", $time, msg);
		end
	endtask

	// one request, answer checked one cycle later
	task automatic access(input lbr_row_type r);
		@(posedge i_clock);
		rd_q <= !r.wr;
		wr_q <= r.wr;
		idx <= r.idx;
		wd <= r.wd;
		priv <= r.priv;
		rm <= r.rm;
		@(posedge i_clock);
		rd_q <= 1'b0;
		wr_q <= 1'b0;
		#1;
		check(done === 1'b1 && fault === r.flt, "access answer");
		if (!r.wr && !r.flt) check(rdata === r.rd, "read data");
	endtask

	task automatic rdx(input logic [3:0] i, input logic [31:0] e);
		access('{1'b0, i, 32'h0, 2'h0, 1'b0, 1'b0, e});
	endtask

	task automatic wctl(input logic [31:0] v);
		access('{1'b1, 4'h0, v, 2'h0, 1'b0, 1'b0, 32'h0});
	endtask

	// k is retired, debug, interrupt, branch
	task automatic ev(input logic [3:0] k, input logic [3:0] m, input logic [3:0] p, input logic [31:0] a,
		input logic [31:0] b);
		@(posedge i_clock);
		{rt, db, it, br} <= k;
		bm <= m;
		pe <= p;
		f <= a;
		t <= b;
		@(posedge i_clock);
		{rt, db, it, br} <= 4'h0;
		bm <= 4'h0;
		pe <= 4'h0;
		#1;
	endtask

	initial begin
		repeat (20000) @(posedge i_clock);
		n_errors++;
		$display("unexpected %0t run did not finish", $time);
		summarize();
	end

	initial begin
		i_rst_n = 1'b0;
		{rd_q, wr_q, rm, br, it, db, rt, ssf, rdy} = 9'h0;
		{idx, bm, pe, priv} = 14'h0;
		{wd, f, t} = 96'h0;
		base = 32'h1000;
		rows = '{'{1'b1, 4'h0, 32'hffffffff, 2'h3, 1'b0, 1'b1, 32'h0},
			'{1'b0, 4'h0, 32'h0, 2'h0, 1'b0, 1'b0, 32'h0},
			'{1'b1, 4'h0, 32'hffffffbd, 2'h0, 1'b0, 1'b0, 32'h0},
			'{1'b0, 4'h0, 32'h0, 2'h0, 1'b0, 1'b0, 32'h3d},
			'{1'b1, 4'h0, 32'h2, 2'h3, 1'b1, 1'b0, 32'h0},
			'{1'b0, 4'h0, 32'h0, 2'h0, 1'b0, 1'b0, 32'h2},
			'{1'b1, 4'h1, 32'h12345678, 2'h0, 1'b0, 1'b1, 32'h0},
			'{1'b0, 4'h1, 32'h0, 2'h0, 1'b0, 1'b0, 32'h0},
			'{1'b0, 4'h4, 32'h0, 2'h0, 1'b0, 1'b0, 32'h0},
			'{1'b0, 4'h5, 32'h0, 2'h0, 1'b0, 1'b1, 32'h0}};
		repeat (12) @(posedge i_clock);
		i_rst_n <= 1'b1;
		repeat (3) @(posedge i_clock);
		#1;
		check(pins === 4'hf && rdata === 32'h0 && stall === 1'b0, "reset outputs");
		foreach (rows[k]) access(rows[k]);
		wctl(32'h1);
		ev(4'h1, 4'h0, 4'h0, 32'h1010, 32'h2000);
		rdx(4'h1, 32'h10);
		rdx(4'h2, 32'h1000);
		ev(4'h2, 4'h0, 4'h0, 32'h1100, 32'h3000);
		rdx(4'h3, 32'h10);
		rdx(4'h4, 32'h1000);
		rdx(4'h1, 32'h100);
		rdx(4'h2, 32'h2000);
		ev(4'h5, 4'h0, 4'h0, 32'h1500, 32'h1600);
		check(entry === 1'b1, "debug entry");
		rdx(4'h0, 32'h0);
		rdx(4'h1, 32'h100);
		rdx(4'h3, 32'h10);
		ev(4'h1, 4'h0, 4'h0, 32'h1700, 32'h1800);
		rdx(4'h2, 32'h2000);
		wctl(32'h1);
		ev(4'h1, 4'h0, 4'h0, 32'h1700, 32'h1800);
		rdx(4'h2, 32'h800);
		ev(4'h3, 4'h0, 4'h0, 32'h1a00, 32'h1b00);
		rdx(4'h3, 32'ha00);
		rdx(4'h4, 32'hb00);
		rdx(4'h1, 32'ha00);
		@(posedge i_clock);
		ssf <= 1'b1;
		wctl(32'h2);
		ev(4'h8, 4'h0, 4'h0, 32'h0, 32'h0);
		check(trap === 1'b0, "trap on plain step");
		ev(4'h1, 4'h0, 4'h0, 32'h0, 32'h0);
		check(trap === 1'b1, "no trap on branch");
		wctl(32'h0);
		ev(4'h8, 4'h0, 4'h0, 32'h0, 32'h0);
		check(trap === 1'b1, "no trap on step");
		wctl(32'h3c);
		ev(4'h0, 4'h5, 4'ha, 32'h0, 32'h0);
		check(pins === 4'ha, "match pins");
		@(posedge i_clock);
		#1;
		check(pins === 4'hf, "pins not released");
		wctl(32'h0);
		ev(4'h0, 4'h5, 4'ha, 32'h0, 32'h0);
		check(pins === 4'h5, "event pins");
		wctl(32'h41);
		ev(4'h1, 4'h0, 4'h0, 32'h1234, 32'h1300);
		check(tvalid === 1'b1 && stall === 1'b1 && tfrom === 32'h234 && tto === 32'h300, "trace");
		@(posedge i_clock);
		rdy <= 1'b1;
		repeat (3) @(posedge i_clock);
		#1;
		check(tvalid === 1'b0 && stall === 1'b0, "trace not drained");
		@(posedge i_clock);
		i_rst_n <= 1'b0;
		repeat (2) @(posedge i_clock);
		#1;
		check(pins === 4'hf && tvalid === 1'b0 && done === 1'b0, "mid-run reset");
		@(posedge i_clock);
		i_rst_n <= 1'b1;
		repeat (3) @(posedge i_clock);
		rdx(4'h0, 32'h0);
		rdx(4'h2, 32'h0);
		summarize();
	end
endmodule
